// ---- dv/sea_master_model.sv ----
// Two-wire bus master model driving the serial clock and data line
`timescale 1ns/1ps
module sea_master_model (
    output logic      o_scl,
    output logic      o_sda_low,
    input  wire logic i_sda
);
    // Clock stands high between frames, data released to the pull-up
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    // One clock pulse with the data line left untouched; the testbench never calls it
    task automatic pulse();
        o_scl = 1'b0;
        #16;
        o_scl = 1'b1;
        #16;
    endtask
    task automatic start();
        o_sda_low = 1'b1;
        #16;
        o_scl = 1'b0;
        #16;
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack_n);
        for (int i = 7; i >= 0; i--) begin
            o_sda_low = !b[i];
            #16;
            o_scl = 1'b1;
            #16;
            o_scl = 1'b0;
        end
        o_sda_low = 1'b0;
        // Long low phase gives the synchronised acknowledge time to land
        #48;
        ack_n = i_sda;
        o_scl = 1'b1;
        #16;
        o_scl = 1'b0;
        #48;
    endtask
    task automatic stop();
        o_sda_low = 1'b1;
        #16;
        o_scl = 1'b1;
        #16;
        o_sda_low = 1'b0;
        #16;
    endtask
endmodule // sea_master_model

// ---- dv/sea_top_monitor.sv ----
// Checker of link timing, select decode and alarm behaviour at the top ports
`timescale 1ns/1ps
module sea_top_monitor
    import sea_pkg::*;
#(
    parameter int REFRESH_CYC = SEA_REFRESH_CYC
) (
    input wire logic                  i_clk,
    input wire logic                  i_rst_n,
    input wire logic                  i_scl,
    input wire logic [SEA_TEMP_W-1:0] i_temp_adc,
    input wire logic                  i_alarm_enable,
    input wire logic                  i_alarm_mode_select,
    input wire logic                  i_alarm_polarity_high,
    input wire logic                  i_crit_only,
    input wire logic                  i_alarm_clear_bit,
    input wire logic [SEA_TEMP_W-1:0] i_upper_limit,
    input wire logic                  i_busy,
    input wire logic                  o_sda_oe_n,
    input wire logic                  o_sda_out,
    input wire logic                  o_eeprom_sel,
    input wire logic                  o_eeprom_page_select,
    input wire logic                  o_write_protect_sel,
    input wire logic                  o_sensor_sel,
    input wire logic                  o_standby,
    input wire logic [SEA_TEMP_W-1:0] o_temperature,
    input wire logic                  o_alarm_n_oe
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // Alarm settings under which a level check is meaningful
    wire logic cmp_cfg = i_alarm_enable && !i_alarm_mode_select && !i_crit_only && !i_alarm_polarity_high;
    wire logic int_cfg = i_alarm_enable && i_alarm_mode_select && !i_crit_only && !i_alarm_polarity_high;
    int unsigned lag_q;
    // Cycles the latched reading has lagged the converter
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || o_temperature == i_temp_adc) lag_q <= 0;
        else lag_q <= lag_q + 1;
    end
    sda_out_zero_a: assert property (o_sda_out == 1'b0)
        else $error("data line driven high");
    reset_state_a: assert property (disable iff (1'b0) !i_rst_n |=> o_alarm_n_oe && o_sda_oe_n && o_standby)
        else $error("outputs not idle in reset");
    sel_onehot_a: assert property ($onehot0({o_eeprom_sel, o_eeprom_page_select, o_sensor_sel}))
        else $error("two targets selected");
    sel_pair_a: assert property (o_eeprom_page_select == o_write_protect_sel)
        else $error("page and protect selects differ");
    disabled_idle_a: assert property ((!i_alarm_enable)[*4] |-> o_alarm_n_oe)
        else $error("disabled alarm pulls pin");
    standby_busy_a: assert property ($rose(o_standby) |-> !$past(i_busy))
        else $error("standby while busy");
    temp_track_a: assert property ($changed(o_temperature) |-> o_temperature == $past(i_temp_adc)
                                   || o_temperature == $past(i_temp_adc, 2))
        else $error("latched reading not from converter");
    refresh_bound_a: assert property (lag_q <= REFRESH_CYC + 4)
        else $error("reading not refreshed in time");
    ack_edge_a: assert property ($changed(o_sda_oe_n) |-> !i_scl)
        else $error("data line changed with clock high");
    ack_hold_a: assert property ($fell(o_sda_oe_n) |=> (!o_sda_oe_n)[*4])
        else $error("acknowledge too short");
    cmp_alarm_a: assert property ((cmp_cfg && $signed(o_temperature) > $signed(i_upper_limit))[*3]
                                  |-> !o_alarm_n_oe)
        else $error("comparator alarm missing");
    int_hold_a: assert property (int_cfg && $past(int_cfg) && !o_alarm_n_oe && !i_alarm_clear_bit
                                 && !$past(i_alarm_clear_bit) && !$past(i_alarm_clear_bit, 2) |=> !o_alarm_n_oe)
        else $error("interrupt alarm dropped without clear");
    // Main scenarios reached
    ack_c: cover property ($fell(o_sda_oe_n));
    sensor_c: cover property ($rose(o_sensor_sel));
    int_c: cover property (int_cfg && !o_alarm_n_oe);
endmodule // sea_top_monitor
bind sea_top sea_top_monitor #(.REFRESH_CYC(REFRESH_CYC)) i_sea_top_monitor (.*);

// ---- dv/tb.sv ----
// Testbench for address routing and alarm logic
`timescale 1ns/1ps
module tb;
    import sea_pkg::*;
    logic                  i_clk, i_rst_n, i_busy, i_alarm_enable, i_alarm_mode_select, i_scl, sda_low;
    logic                  i_alarm_polarity_high, i_crit_only, i_alarm_clear_bit, ack_n;
    logic                  i_addr_select_hi, i_addr_select_mid, i_addr_select_lo;
    logic [1:0]            i_hyst_sel;
    logic [3:0]            c;
    logic [SEA_TEMP_W-1:0] i_temp_adc, i_upper_limit, i_lower_limit, i_crit_limit, o_temperature;
    logic                  o_sda_oe_n, o_sda_out, o_eeprom_sel, o_eeprom_page_select, o_write_protect_sel;
    logic                  o_sensor_sel, o_read, o_standby, o_alarm_n_oe;
    wire                   i_sda;
    int                    miscompares, total_checks;
    logic [3:0]            codes [3] = '{SEA_TYPE_EEPROM, SEA_TYPE_PROTECT, SEA_TYPE_SENSOR};
    logic [7:0]            bad [3] = '{8'h5A, 8'hA8, 8'h3F};
    // Open-drain wire with pull-up
    assign i_sda = !sda_low && o_sda_oe_n;
    sea_top #(.REFRESH_CYC(50)) i_sea_top (.*);
    sea_master_model i_sea_master_model (.o_scl(i_scl), .o_sda_low(sda_low), .i_sda(i_sda));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic finish_test();
        if (miscompares == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk1(input string n, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            $display("unexpected %s expected %b seen %b", n, e, g);
            miscompares++;
        end
    endtask
    task automatic chk11(input string n, input logic [SEA_TEMP_W-1:0] e, input logic [SEA_TEMP_W-1:0] g);
        total_checks++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    // New reading, wait past one refresh, then look at the pin
    task automatic step(input logic [SEA_TEMP_W-1:0] t, input logic e);
        i_temp_adc = t;
        wait_cyc(70);
        chk1("alarm_oe_n", e, o_alarm_n_oe);
    endtask
    task automatic clear();
        i_alarm_clear_bit = 1'b1;
        wait_cyc(1);
        i_alarm_clear_bit = 1'b0;
        wait_cyc(5);
        chk1("alarm_oe_n", 1'b1, o_alarm_n_oe);
    endtask
    // Hang guard well beyond the expected run
    initial begin
        #100000;
        miscompares++;
        finish_test();
    end
    initial begin
        {i_rst_n, i_busy, i_alarm_enable, i_alarm_mode_select, i_alarm_polarity_high} = '0;
        {i_crit_only, i_alarm_clear_bit, i_hyst_sel, i_temp_adc, i_lower_limit} = '0;
        {i_addr_select_hi, i_addr_select_mid, i_addr_select_lo} = 3'h5;
        i_upper_limit = 11'h0C8;
        i_crit_limit = 11'h12C;
        wait_cyc(1);
        i_sea_master_model.start();
        i_sea_master_model.stop();
        wait_cyc(5);
        i_rst_n = 1'b1;
        wait_cyc(1);
        chk1("alarm_oe_n", 1'b1, o_alarm_n_oe);
        chk1("standby", 1'b1, o_standby);
        for (int i = 0; i < 6; i++) begin
            c = codes[i / 2];
            i_temp_adc = 11'h010 + 11'(i);
            i_sea_master_model.start();
            i_sea_master_model.send_byte({c, 3'h5, 1'(i % 2)}, ack_n);
            wait_cyc(4);
            chk1("ack", 1'b0, ack_n);
            chk1("eeprom_sel", c == SEA_TYPE_EEPROM, o_eeprom_sel);
            chk1("page_sel", c == SEA_TYPE_PROTECT, o_eeprom_page_select);
            chk1("protect_sel", c == SEA_TYPE_PROTECT, o_write_protect_sel);
            chk1("sensor_sel", c == SEA_TYPE_SENSOR, o_sensor_sel);
            chk1("read", 1'(i % 2), o_read);
            chk1("standby", 1'b0, o_standby);
            i_sea_master_model.stop();
            wait_cyc(60);
            chk1("standby", 1'b1, o_standby);
            chk11("temperature", i_temp_adc, o_temperature);
        end
        for (int i = 0; i < 3; i++) begin
            i_sea_master_model.start();
            i_sea_master_model.send_byte(bad[i], ack_n);
            wait_cyc(4);
            chk1("ack", 1'b1, ack_n);
            chk1("sel", 1'b0, o_eeprom_sel | o_sensor_sel | o_eeprom_page_select);
            chk1("standby", 1'b1, o_standby);
            i_sea_master_model.stop();
        end
        i_busy = 1'b1;
        i_sea_master_model.start();
        i_sea_master_model.send_byte(8'hAA, ack_n);
        i_sea_master_model.stop();
        wait_cyc(20);
        chk1("standby", 1'b0, o_standby);
        i_busy = 1'b0;
        wait_cyc(10);
        chk1("standby", 1'b1, o_standby);
        i_alarm_enable = 1'b1;
        i_hyst_sel = 2'h1;
        step(11'h064, 1'b1);
        step(11'h0FA, 1'b0);
        step(11'h0C3, 1'b0);
        step(11'h0B4, 1'b1);
        step(11'h7D8, 1'b0);
        step(11'h064, 1'b1);
        i_alarm_polarity_high = 1'b1;
        step(11'h0FA, 1'b1);
        step(11'h064, 1'b0);
        i_alarm_polarity_high = 1'b0;
        i_alarm_mode_select = 1'b1;
        step(11'h0FA, 1'b0);
        step(11'h0FA, 1'b0);
        clear();
        step(11'h064, 1'b0);
        clear();
        i_alarm_mode_select = 1'b0;
        i_crit_only = 1'b1;
        step(11'h15E, 1'b0);
        step(11'h127, 1'b0);
        step(11'h118, 1'b1);
        i_crit_only = 1'b0;
        step(11'h0FA, 1'b0);
        i_rst_n = 1'b0;
        i_sea_master_model.start();
        i_sea_master_model.stop();
        wait_cyc(5);
        i_rst_n = 1'b1;
        wait_cyc(1);
        chk1("alarm_oe_n", 1'b1, o_alarm_n_oe);
        i_alarm_enable = 1'b0;
        step(11'h0FA, 1'b1);
        finish_test();
    end
endmodule // tb

// ---- verilog/sea_addr_link.sv ----
// Address byte receiver and acknowledge driver clocked by the serial clock
`timescale 1ns/1ps
module sea_addr_link
    import sea_pkg::*;
(
    input  wire logic       i_scl,
    input  wire logic       i_rst_n,
    input  wire logic       i_sda,
    input  wire logic       i_start,
    input  wire logic       i_stop,
    input  wire logic [2:0] i_addr_pins,
    output logic            o_sda_oe_n,
    output logic            o_hit_tgl,
    output logic [1:0]      o_target,
    output logic            o_read
);
    logic [7:0] shift_q;
    logic [3:0] cnt_q;
    logic       ack_q;
    logic       done_q;
    logic [7:0] byte_w;

    assign byte_w = {shift_q[6:0], i_sda};

    function automatic logic [1:0] decode_type(input logic [3:0] code);
        case (code)
            SEA_TYPE_EEPROM:  decode_type = SEA_TGT_EEPROM;
            SEA_TYPE_PROTECT: decode_type = SEA_TGT_PROTECT;
            SEA_TYPE_SENSOR:  decode_type = SEA_TGT_SENSOR;
            default:          decode_type = SEA_TGT_NONE;
        endcase
    endfunction

    // MSB first after start
    // The start flag is still up at the first rising clock, which already carries bit 7
    always_ff @(posedge i_scl) begin
        if (!i_rst_n) begin
            shift_q <= 8'h00;
            cnt_q   <= 4'h0;
        end else if (i_start) begin
            shift_q <= {7'h00, i_sda};
            cnt_q   <= 4'h1;
        end else if (i_stop) begin
            shift_q <= 8'h00;
            cnt_q   <= 4'h0;
        end else if (!done_q) begin
            shift_q <= byte_w;
            cnt_q   <= cnt_q + 4'h1;
        end
    end

    // field split; type decode; device select match; read bit
    always_ff @(posedge i_scl) begin
        if (!i_rst_n || i_start || i_stop) begin
            done_q    <= 1'b0;
            ack_q     <= 1'b0;
            o_hit_tgl <= o_hit_tgl & i_rst_n;
            o_target  <= SEA_TGT_NONE;
            o_read    <= 1'b0;
        end else if (!done_q && cnt_q == SEA_BITS_PER_BYTE - 4'h1) begin
            done_q <= 1'b1;
            if (byte_w[SEA_DEVSEL_MSB:SEA_DEVSEL_LSB] == i_addr_pins &&
                decode_type(byte_w[SEA_TYPE_MSB:SEA_TYPE_LSB]) != SEA_TGT_NONE) begin
                ack_q     <= 1'b1;
                o_hit_tgl <= ~o_hit_tgl;
                o_target  <= decode_type(byte_w[SEA_TYPE_MSB:SEA_TYPE_LSB]);
                o_read    <= byte_w[SEA_RW_BIT];
            end
        end else begin
            ack_q <= 1'b0;
        end
    end

    // ack in ninth clock; drive low only, changed on falling edge
    always_ff @(negedge i_scl) begin
        if (!i_rst_n)
            o_sda_oe_n <= 1'b1;
        else
            o_sda_oe_n <= ~ack_q;
    end
endmodule // sea_addr_link

// ---- verilog/sea_pkg.sv ----
// Package: constants for the sensor/EEPROM address decoder and alarm logic
package sea_pkg;
    localparam logic [3:0] SEA_TYPE_EEPROM  = 4'hA;   // EEPROM read/write target
    localparam logic [3:0] SEA_TYPE_PROTECT = 4'h6;   // Page select and write protection
    localparam logic [3:0] SEA_TYPE_SENSOR  = 4'h3;   // Temperature sensor
    localparam int SEA_TYPE_MSB    = 7;
    localparam int SEA_TYPE_LSB    = 4;
    localparam int SEA_DEVSEL_MSB  = 3;
    localparam int SEA_DEVSEL_LSB  = 1;
    localparam int SEA_RW_BIT      = 0;
    localparam int SEA_CFG_MODE_BIT  = 0;            // alarm_mode_select position
    localparam int SEA_CFG_CLEAR_BIT = 5;            // alarm_clear_bit position
    localparam int SEA_TEMP_W      = 11;
    localparam int SEA_CLK_MHZ     = 100;
    localparam int SEA_REFRESH_HZ  = 8;              // Least refresh rate
    // Longest refresh interval rounded down to whole cycles
    localparam int SEA_REFRESH_CYC = (SEA_CLK_MHZ * 1000000) / SEA_REFRESH_HZ;
    localparam logic [SEA_TEMP_W-1:0] SEA_LIMIT_RST = 11'h000;  // 0 degC
    localparam logic [1:0] SEA_HYST_RST = 2'h0;      // Zero hysteresis
    localparam logic [3:0] SEA_BITS_PER_BYTE = 4'h8;
    typedef enum logic [1:0] {SEA_TGT_NONE, SEA_TGT_EEPROM, SEA_TGT_PROTECT, SEA_TGT_SENSOR} sea_target_t;
endpackage

// ---- verilog/sea_top.sv ----
// Top: address routing front end and temperature alarm logic
// Summary of operation
// - EEPROM and sensor logic run side by side, never blocking each other.
// - Address byte: type code bits 7-4, select bits 3-1, rw bit 0.
// - Type codes 1010 EEPROM, 0110 protect/page, 0011 sensor recognised.
// - Code 0110 gives access to the page select function.
// - Code 0110 also gives access to software write protection.
// - Select bits must equal the three address pins.
// - Read/write bit one means read, zero means write.
// - Match acknowledges in ninth clock; mismatch leaves line released, standby.
// - Temperature refreshed at least eight times per second and latched.
// - Data line only pulled low or released.
// - Interrupt mode alarm holds until clear bit five is written.
// - Config bit zero selects interrupt or comparator behaviour.
// - Below critical limits, normal selected mode resumes.
// - Comparator mode alarm follows the condition.
// - Critical alarm holds until below critical minus hysteresis.
// - Every threshold applies the selected hysteresis on release.
// - Upper and lower limits form a window; enter and exit trigger.
// - After reset: alarm disabled, deasserted, comparator, active low, no hysteresis; reset here only deasserts the pin, enable/mode/polarity/hysteresis are inputs.
// - Standby after stop once internal work is done.
`timescale 1ns/1ps
module sea_top
    import sea_pkg::*;
#(
    parameter int REFRESH_CYC = SEA_REFRESH_CYC
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_scl,
    input  wire logic                  i_sda,
    input  wire logic                  i_addr_select_hi,
    input  wire logic                  i_addr_select_mid,
    input  wire logic                  i_addr_select_lo,
    input  wire logic [SEA_TEMP_W-1:0] i_temp_adc,
    input  wire logic                  i_alarm_enable,
    input  wire logic                  i_alarm_mode_select,
    input  wire logic                  i_alarm_polarity_high,
    input  wire logic                  i_crit_only,
    input  wire logic [1:0]            i_hyst_sel,
    input  wire logic                  i_alarm_clear_bit,
    input  wire logic [SEA_TEMP_W-1:0] i_upper_limit,
    input  wire logic [SEA_TEMP_W-1:0] i_lower_limit,
    input  wire logic [SEA_TEMP_W-1:0] i_crit_limit,
    input  wire logic                  i_busy,
    output logic                       o_sda_oe_n,
    output logic                       o_sda_out,
    output logic                       o_eeprom_sel,
    output logic                       o_eeprom_page_select,
    output logic                       o_write_protect_sel,
    output logic                       o_sensor_sel,
    output logic                       o_read,
    output logic                       o_standby,
    output logic [SEA_TEMP_W-1:0]      o_temperature,
    output logic                       o_alarm_n_oe
);
    // Link side: start/stop detection on data edges while the serial clock is high
    logic start_q;
    logic stop_q;
    logic link_oe_n;
    logic hit_tgl;
    logic [1:0] target_l;
    logic read_l;

    // Start and stop toggle on data edges with clock high; a rising clock takes a copy,
    // so a zero data bit at a rising clock can never pose as a start
    logic start_tgl_q;
    logic stop_tgl_q;
    logic start_seen_q;
    logic stop_seen_q;
    always_ff @(negedge i_sda) begin
        if (!i_rst_n)
            start_tgl_q <= 1'b0;
        else if (i_scl)
            start_tgl_q <= ~start_tgl_q;
    end

    // Stop toggle: data rising with clock high
    always_ff @(posedge i_sda) begin
        if (!i_rst_n)
            stop_tgl_q <= 1'b0;
        else if (i_scl)
            stop_tgl_q <= ~stop_tgl_q;
    end

    // Copies taken at each rising clock end the start and stop levels
    always_ff @(posedge i_scl) begin
        if (!i_rst_n) begin
            start_seen_q <= 1'b0;
            stop_seen_q  <= 1'b0;
        end else begin
            start_seen_q <= start_tgl_q;
            stop_seen_q  <= stop_tgl_q;
        end
    end

    assign start_q = start_tgl_q ^ start_seen_q;
    assign stop_q  = stop_tgl_q ^ stop_seen_q;

    sea_addr_link u_link (
        .i_scl       (i_scl),
        .i_rst_n     (i_rst_n),
        .i_sda       (i_sda),
        .i_start     (start_q),
        .i_stop      (stop_q),
        .i_addr_pins ({i_addr_select_hi, i_addr_select_mid, i_addr_select_lo}),
        .o_sda_oe_n  (link_oe_n),
        .o_hit_tgl   (hit_tgl),
        .o_target    (target_l),
        .o_read      (read_l)
    );

    // Synchronisers: first stage feeds only the second
    logic [2:0] hit_s1_q, hit_s2_q;
    logic [1:0] stop_s1_q, stop_s2_q;
    logic       oe_s1_q, oe_s2_q;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            hit_s1_q  <= 3'h0;
            hit_s2_q  <= 3'h0;
            stop_s1_q <= 2'h0;
            stop_s2_q <= 2'h0;
            oe_s1_q   <= 1'b1;
            oe_s2_q   <= 1'b1;
        end else begin
            hit_s1_q  <= {hit_tgl, 2'h0};
            hit_s2_q  <= {hit_s1_q[2], hit_s2_q[2], 1'b0};
            stop_s1_q <= {stop_q, 1'b0};
            stop_s2_q <= {stop_s1_q[1], stop_s2_q[1]};
            oe_s1_q   <= link_oe_n;
            oe_s2_q   <= oe_s1_q;
        end
    end

    logic hit_evt;
    logic stop_evt;
    assign hit_evt  = hit_s2_q[2] ^ hit_s2_q[1];
    assign stop_evt = stop_s2_q[1] & ~stop_s2_q[0];

    // open drain: output level fixed low, only the enable moves
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_sda_oe_n <= 1'b1;
            o_sda_out  <= 1'b0;
        end else begin
            o_sda_oe_n <= oe_s2_q;
            o_sda_out  <= 1'b0;
        end
    end

    // Target routing; the link target word is stable long before the toggle lands
    // route to one target
    // page select access; write protection access
    // sensor logic below runs regardless of selection
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_eeprom_sel         <= 1'b0;
            o_eeprom_page_select <= 1'b0;
            o_write_protect_sel  <= 1'b0;
            o_sensor_sel         <= 1'b0;
            o_read               <= 1'b0;
        end else if (hit_evt) begin
            o_eeprom_sel         <= (target_l == SEA_TGT_EEPROM);
            o_eeprom_page_select <= (target_l == SEA_TGT_PROTECT);
            o_write_protect_sel  <= (target_l == SEA_TGT_PROTECT);
            o_sensor_sel         <= (target_l == SEA_TGT_SENSOR);
            o_read               <= read_l;
        end else if (stop_evt) begin
            o_eeprom_sel         <= 1'b0;
            o_eeprom_page_select <= 1'b0;
            o_write_protect_sel  <= 1'b0;
            o_sensor_sel         <= 1'b0;
            o_read               <= 1'b0;
        end
    end

    // standby after stop once busy ends; mismatch stays in standby
    logic stop_pend_q;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            stop_pend_q <= 1'b0;
            o_standby   <= 1'b1;
        end else begin
            if (hit_evt) begin
                o_standby   <= 1'b0;
                stop_pend_q <= 1'b0;
            end else if (stop_evt) begin
                stop_pend_q <= 1'b1;
            end else if (stop_pend_q && !i_busy) begin
                o_standby   <= 1'b1;
                stop_pend_q <= 1'b0;
            end
        end
    end

    // refresh timer latches a new reading each interval
    logic [31:0] ref_cnt_q;
    logic        sample_q;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ref_cnt_q     <= 32'h0;
            sample_q      <= 1'b0;
            o_temperature <= SEA_LIMIT_RST;
        end else begin
            sample_q <= 1'b0;
            if (ref_cnt_q >= 32'(REFRESH_CYC - 1)) begin
                ref_cnt_q     <= 32'h0;
                sample_q      <= 1'b1;
                o_temperature <= i_temp_adc;
            end else begin
                ref_cnt_q <= ref_cnt_q + 32'h1;
            end
        end
    end

    // Hysteresis selection: 0, 1.5, 3, 6 degC in 0.125 steps (0/12/24/48 LSB)
    // hysteresis for every threshold
    logic signed [SEA_TEMP_W+1:0] hyst_w;
    always_comb begin
        case (i_hyst_sel)
            2'h0:    hyst_w = 13'sh000;
            2'h1:    hyst_w = 13'sh00C;
            2'h2:    hyst_w = 13'sh018;
            default: hyst_w = 13'sh030;
        endcase
    end

    // Signed compare helpers; temperatures are two's complement
    function automatic logic signed [SEA_TEMP_W+1:0] sx(input logic [SEA_TEMP_W-1:0] v);
        sx = {{2{v[SEA_TEMP_W-1]}}, v};
    endfunction

    logic signed [SEA_TEMP_W+1:0] t_w;
    assign t_w = sx(o_temperature);

    // window error with hysteresis on return; window state
    logic out_win_q;
    logic crit_q;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            out_win_q <= 1'b0;
            crit_q    <= 1'b0;
        end else if (sample_q) begin
            if (!out_win_q)
                out_win_q <= (t_w > sx(i_upper_limit)) || (t_w < sx(i_lower_limit));
            else
                out_win_q <= (t_w > sx(i_upper_limit) - hyst_w) ||
                             (t_w < sx(i_lower_limit) + hyst_w);
            // critical set above limit, release below limit minus hysteresis
            if (!crit_q)
                crit_q <= (t_w > sx(i_crit_limit));
            else
                crit_q <= !(t_w < sx(i_crit_limit) - hyst_w);
        end
    end

    // Window transitions, both entering and leaving, fire the interrupt
    logic out_win_d1_q;
    logic irq_q;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n)
            out_win_d1_q <= 1'b0;
        else
            out_win_d1_q <= out_win_q;
    end

    // sticky interrupt; trigger wins over a clear in the same cycle
    always_ff @(posedge i_clk) begin
        if (!i_rst_n)
            irq_q <= 1'b0;
        else if (out_win_q != out_win_d1_q)
            irq_q <= 1'b1;
        else if (i_alarm_clear_bit)
            irq_q <= 1'b0;
    end

    // mode bit picks behaviour; comparator follows condition
    // critical released: selected mode resumes; reset state off
    logic alarm_w;
    always_comb begin
        if (crit_q)
            alarm_w = 1'b1;
        else if (i_crit_only)
            alarm_w = 1'b0;
        else if (i_alarm_mode_select)
            alarm_w = irq_q;
        else
            alarm_w = out_win_q;
    end

    // Open-drain alarm pin: enable low pulls it low; polarity picks the asserted level
    always_ff @(posedge i_clk) begin
        if (!i_rst_n)
            o_alarm_n_oe <= 1'b1;
        else if (!i_alarm_enable)
            o_alarm_n_oe <= 1'b1;
        else
            o_alarm_n_oe <= i_alarm_polarity_high ? alarm_w : ~alarm_w;
    end
endmodule // sea_top
